// >>> hdl/mac_control.sv
// Control and datapath of the four-multiplier 40-bit accumulator.
// Assumes all pins but clk_sys and sys_rst are asynchronous to clk_sys and the host holds its
// strobes long enough to be seen through a two-stage synchroniser.
`timescale 1ns/1ps
module mac_control (
  input  wire  logic        clk_sys,       // System clock, 40 MHz.
  input  wire  logic        sys_rst,       // Synchronous reset.
  input  wire  logic        csN,           // Chip select.
  input  wire  logic        wrN,           // Write strobe.
  input  wire  logic        rdN,           // Read strobe.
  input  wire  logic [15:0] hostDataIn,    // Data bus input half.
  input  wire  logic        ifaceModePin,  // Direct parameter mode.
  input  wire  logic [1:0]  accumCtl,      // Accumulator control.
  input  wire  logic        sampleLoad,    // Sample register load.
  input  wire  logic [3:0]  multZeroCtl,   // Multiplier zero control.
  input  wire  logic [7:0]  operandPortA,  // Operand port A.
  input  wire  logic [7:0]  operandPortB,  // Operand port B.
  input  wire  logic [7:0]  operandPortC,  // Operand port C.
  input  wire  logic [7:0]  operandPortD,  // Operand port D.
  input  wire  logic [7:0]  operandPortE,  // Operand port E.
  input  wire  logic [7:0]  operandPortF,  // Operand port F.
  input  wire  logic [7:0]  operandPortG,  // Operand port G.
  input  wire  logic [7:0]  operandPortH,  // Operand port H.
  output logic       [15:0] hostDataOut,   // Data bus output half.
  output logic              hostDataOeN,   // Low while driving the bus.
  output logic       [19:0] resultWord,    // Fixed or float result.
  output logic       [15:0] activeCtrl     // Host control register; in force outside direct mode.
);

  mac_control_pkg::pins_s      pinNow;      // Raw pin bundle.
  mac_control_pkg::pins_s      pinMeta_ff;  // First synchroniser stage.
  mac_control_pkg::pins_s      pinSync_ff;  // Second synchroniser stage.
  mac_control_pkg::ctrlWord_s  ctrl_ff;     // Host control register.
  mac_control_pkg::ctrlWord_s  effCtrl;     // Register or direct bus.
  mac_control_pkg::ctrlWord_s  s1Ctrl_ff;   // Control with operands.
  mac_control_pkg::ctrlWord_s  s2Ctrl_ff;   // Control with products.
  mac_control_pkg::ctrlWord_s  s3Ctrl_ff;   // Control with sample.
  mac_control_pkg::accumOp_e   s1Acc_ff;    // Accumulator op, stage 1.
  mac_control_pkg::accumOp_e   s2Acc_ff;    // Accumulator op, stage 2.
  mac_control_pkg::floatWord_s floatNow;    // Encoded sample.
  logic [15:0]     wrData_ff;               // Word captured by a write.
  logic            wrActive_ff;             // Write seen last cycle.
  logic [mac_control_pkg::WRITE_LATENCY-2:0] pend_ff;  // Commit delay.
  logic            writeActive;             // Write strobes both low outside direct mode.
  logic            writeEnd;                // Write just finished.
  logic            readActive;              // Read strobes both low.
  logic [7:0][7:0] opnd_ff;                 // Zeroed operands.
  logic            s1Smp_ff;                // Sample load, stage 1.
  logic            s2Smp_ff;                // Sample load, stage 2.
  logic signed [39:0] term;                 // Signed product sum.
  logic signed [39:0] term_ff;              // Registered product sum.
  logic signed [39:0] sum_ff;               // Accumulator.
  logic signed [39:0] nxtSum;               // Next accumulator value.
  logic signed [39:0] sample_ff;            // Sample register.
  logic [15:0]     hostDataOut_ff;          // Read data register.
  logic            hostDataOeN_ff;          // Output enable register.
  logic [19:0]     resultWord_ff;           // Result register.

  // Widens an 8- or 16-bit operand pair and multiplies them.
  function automatic logic signed [33:0] mulWide(input logic [15:0] a,
                                                 input logic [15:0] b,
                                                 input logic uns);
    logic signed [16:0] ea;
    logic signed [16:0] eb;
    ea = $signed({~uns & a[15], a});
    eb = $signed({~uns & b[15], b});
    return ea * eb;
  endfunction : mulWide

  // Extends an 8-bit operand to 16 bits by sign or zero.
  function automatic logic [15:0] ext8(input logic [7:0] v,
                                       input logic uns);
    return uns ? {8'h00, v} : {{8{v[7]}}, v};
  endfunction : ext8

  // Encodes a 40-bit sum as a float word with truncated mantissa.
  function automatic mac_control_pkg::floatWord_s toFloat(
      input logic signed [39:0] v);
    mac_control_pkg::floatWord_s f;
    logic [39:0] mag;
    logic [39:0] norm;
    int          lead;
    int          e;
    f    = '0;
    mag  = v[39] ? 40'(-v) : v;
    lead = -1;
    for (int i = 0; i < mac_control_pkg::SUM_W; i++) begin
      if (mag[i]) begin
        lead = i;
      end
    end
    f.sign = v[39];                                               // RULE8
    if (lead >= 0) begin
      // The leading one is the implied integer digit.
      norm = mag << (39 - lead);                                  // RULE10
      e    = lead + mac_control_pkg::FLOAT_BIAS;                  // RULE9
      if (e > mac_control_pkg::FLOAT_EXP_MAX) begin
        e = mac_control_pkg::FLOAT_EXP_MAX;
      end
      f.exponent = 6'(e);
      f.mantissa = norm[38:30];
    end
    // A zero sum leaves both fields zero.                           RULE11
    return f;
  endfunction : toFloat

  // Picks twenty bits of the sample and rounds unless truncating.
  function automatic logic [19:0] toFixed(input logic signed [39:0] v,
                                          input logic [4:0] sel,
                                          input logic trunc);
    logic signed [39:0] sh;
    logic               rnd;
    sh  = v >>> sel;
    rnd = (!trunc && sel != 5'h00) ? v[sel - 5'h01] : 1'b0;
    return sh[19:0] + {19'h00000, rnd};
  endfunction : toFixed

  assign pinNow = {accumCtl, sampleLoad, multZeroCtl,
                   operandPortH, operandPortG, operandPortF, operandPortE,
                   operandPortD, operandPortC, operandPortB, operandPortA,
                   hostDataIn, ifaceModePin, csN, wrN, rdN};

  // Two-stage synchroniser; all pins move together so controls stay
  // aligned with the operands sampled beside them.
  always_ff @(posedge clk_sys) begin
    pinMeta_ff <= pinNow;                                         // RULE16
    pinSync_ff <= pinMeta_ff;
  end

  assign writeActive = !pinSync_ff.csN && !pinSync_ff.wrN
                       && !pinSync_ff.ifaceMode;
  assign readActive  = !pinSync_ff.csN && !pinSync_ff.rdN;        // RULE6
  assign writeEnd    = wrActive_ff && !writeActive;

  // Host write capture: the last word seen while the strobes are low wins.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wrData_ff   <= mac_control_pkg::CTRL_RESET;
      wrActive_ff <= 1'b0;
      pend_ff     <= '0;
    end else begin
      wrActive_ff <= writeActive;
      if (writeActive) begin
        wrData_ff <= pinSync_ff.hostDataBus;
      end
      // The shift register drops its oldest bit on purpose.
      pend_ff <= (mac_control_pkg::WRITE_LATENCY-1)'(
                   {pend_ff, writeEnd});                          // RULE14
    end
  end

  // Control register; a new word replaces the whole earlier set.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_ff <= mac_control_pkg::CTRL_RESET;                     // RULE2
    end else if (pend_ff[mac_control_pkg::WRITE_LATENCY-2]) begin
      ctrl_ff <= wrData_ff;                                       // RULE14
    end
  end

  // Direct mode takes the whole word from the bus every cycle.
  assign effCtrl = pinSync_ff.ifaceMode ? pinSync_ff.hostDataBus
                                        : ctrl_ff;                // RULE15

  // Read port: drives the control word only during a qualified read.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hostDataOut_ff <= 16'h0000;
      hostDataOeN_ff <= 1'b1;
    end else begin
      hostDataOeN_ff <= !(readActive && !pinSync_ff.ifaceMode);  // RULE6
      if (readActive) begin
        hostDataOut_ff <= ctrl_ff;
      end
    end
  end

  // Operand stage: zeroing and direct controls are taken from pins here.
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      opnd_ff[2*i]   <= pinSync_ff.multZeroCtl[i] ? 8'h00
                        : pinSync_ff.operands[2*i];               // RULE1
      opnd_ff[2*i+1] <= pinSync_ff.multZeroCtl[i] ? 8'h00
                        : pinSync_ff.operands[2*i+1];             // RULE1
    end
    s1Acc_ff  <= mac_control_pkg::accumOp_e'(pinSync_ff.accumCtl); // RULE5
    s1Smp_ff  <= pinSync_ff.sampleLoad;                           // RULE5
    s1Ctrl_ff <= effCtrl;                                         // RULE4
  end

  // Product combination with the real-time add/subtract selector.
  always_comb begin
    logic               uns;
    logic signed [39:0] p0;
    logic signed [39:0] p1;
    logic signed [39:0] p2;
    logic signed [39:0] p3;
    logic signed [39:0] grpA;
    logic signed [39:0] grpB;
    logic signed [39:0] raw;
    uns  = s1Ctrl_ff.multModeSel[0];
    p0   = 40'(mulWide(ext8(opnd_ff[0], uns), ext8(opnd_ff[1], uns), uns));
    p1   = 40'(mulWide(ext8(opnd_ff[2], uns), ext8(opnd_ff[3], uns), uns));
    p2   = 40'(mulWide(ext8(opnd_ff[4], uns), ext8(opnd_ff[5], uns), uns));
    p3   = 40'(mulWide(ext8(opnd_ff[6], uns), ext8(opnd_ff[7], uns), uns));
    grpA = s1Ctrl_ff.addSubSel[0] ? p0 - p1 : p0 + p1;            // RULE4
    grpB = s1Ctrl_ff.addSubSel[1] ? p2 - p3 : p2 + p3;
    raw  = s1Ctrl_ff.addSubSel[2] ? grpA - grpB : grpA + grpB;
    if (s1Ctrl_ff.multModeSel[1]) begin
      // Wide mode: A:B times C:D, ports E to H ignored.
      raw = 40'(mulWide({opnd_ff[0], opnd_ff[1]},
                        {opnd_ff[2], opnd_ff[3]}, uns));
    end
    term = s1Ctrl_ff.addSubSel[3] ? -raw : raw;
  end

  // Product stage register.
  always_ff @(posedge clk_sys) begin
    term_ff   <= term;
    s2Acc_ff  <= s1Acc_ff;
    s2Smp_ff  <= s1Smp_ff;
    s2Ctrl_ff <= s1Ctrl_ff;
  end

  // Accumulator operation select.
  always_comb begin
    case (s2Acc_ff)
      mac_control_pkg::ACC_ADD:   nxtSum = sum_ff + term_ff;      // RULE12
      mac_control_pkg::ACC_HOLD:  nxtSum = sum_ff;                // RULE12
      mac_control_pkg::ACC_LOAD:  nxtSum = term_ff;               // RULE12
      mac_control_pkg::ACC_CLEAR: nxtSum = '0;                    // RULE12
      default:                    nxtSum = sum_ff;
    endcase
  end

  // Accumulator and sample register; cleared on reset for a clean start.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sum_ff    <= '0;
      sample_ff <= '0;
    end else begin
      sum_ff <= nxtSum;
      if (s2Smp_ff) begin
        sample_ff <= nxtSum;                                      // RULE13
      end
    end
    s3Ctrl_ff <= s2Ctrl_ff;
  end

  assign floatNow = toFloat(sample_ff);

  // Output register: float in the low sixteen bits or fixed twenty bits.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      resultWord_ff <= 20'h00000;
    end else if (s3Ctrl_ff.outFormatSel) begin
      resultWord_ff <= toFixed(sample_ff, s3Ctrl_ff.outBitSelect,
                               s3Ctrl_ff.roundTruncSel);
    end else begin
      resultWord_ff <= {4'h0, floatNow};                          // RULE8
    end
  end

  assign hostDataOut = hostDataOut_ff;
  assign hostDataOeN = hostDataOeN_ff;
  assign resultWord  = resultWord_ff;
  assign activeCtrl  = ctrl_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_zero_pair: assert property ( // RULE1
    pinSync_ff.multZeroCtl[0] |=> opnd_ff[0] == 8'h00 && opnd_ff[1] == 8'h00)
    else $error("zeroed pair carried data");
  a_reset_clear: assert property ( // RULE2
    $fell(sys_rst) |-> ctrl_ff == mac_control_pkg::CTRL_RESET)
    else $error("control word not cleared by reset");
  a_field_layout: assert property ( // RULE3
    pend_ff[0] |=> ctrl_ff.outBitSelect == $past(wrData_ff[8:4])
                   && ctrl_ff.multModeSel == $past(wrData_ff[1:0]))
    else $error("control fields misplaced");
  a_addsub_direct: assert property ( // RULE4
    pinSync_ff.ifaceMode |=> s1Ctrl_ff.addSubSel
                             == $past(pinSync_ff.hostDataBus[15:12]))
    else $error("add/subtract field not sampled with data");
  a_direct_pins: assert property ( // RULE5
    ##1 s1Smp_ff == $past(pinSync_ff.sampleLoad)
    ##1 s2Smp_ff == $past(s1Smp_ff))
    else $error("direct control lost alignment");
  a_read_qualify: assert property ( // RULE6
    !hostDataOeN |-> $past(!pinSync_ff.csN && !pinSync_ff.rdN))
    else $error("bus driven without read");
  a_float_one: assert property ( // RULE9
    sample_ff == 40'sd1
    |-> floatNow.exponent == 6'(mac_control_pkg::FLOAT_BIAS))
    else $error("exponent bias wrong");
  a_float_lead: assert property ( // RULE10
    sample_ff != '0 |-> floatNow.exponent != 6'h00)
    else $error("nonzero value with zero exponent");
  a_float_zero: assert property ( // RULE11
    floatNow.exponent == 6'h00 |-> floatNow.mantissa == 9'h000)
    else $error("denormal produced");
  a_accum_clear: assert property ( // RULE12
    s2Acc_ff == mac_control_pkg::ACC_CLEAR
    ##1 s2Acc_ff == mac_control_pkg::ACC_HOLD
    |=> sum_ff == '0)
    else $error("accumulator not cleared");
  a_sample_hold: assert property ( // RULE13
    !s2Smp_ff |=> $stable(sample_ff))
    else $error("sample register changed while holding");
  a_write_delay: assert property ( // RULE14
    writeEnd |-> ##2 ctrl_ff == $past(wrData_ff, 2))
    else $error("write did not commit after two cycles");
  a_direct_mode: assert property ( // RULE15
    pinSync_ff.ifaceMode |=> s1Ctrl_ff == $past(pinSync_ff.hostDataBus))
    else $error("direct mode word not taken from bus");

  c_write_commit: cover property (writeEnd ##2 ctrl_ff != '0);
  c_host_read: cover property (!hostDataOeN);
  c_sample_load: cover property (
    s2Smp_ff && s2Acc_ff == mac_control_pkg::ACC_ADD);

endmodule : mac_control

// >>> hdl/mac_control_pkg.sv
// Package for the multiply-accumulate control block: control word layout,
// pin bundle, float word layout, accumulator operations and constants.
// Assumes a single 40 MHz system clock and a synchronous active-high reset.
// Functional notes
// RULE1 - Zero bit forces its multiplier pair operands
// RULE2 - Reset clears every control register field
// RULE3 - Fixed fields occupy control word bits 11:0
// RULE4 - Add/subtract selector in bits 15:12, real-time
// RULE5 - Accumulator, sample, zero controls come from pins
// RULE6 - Read only while chip select and read low
// RULE7 - Controller should zero multipliers when idle
// RULE8 - Float word: sign, 6-bit exponent, 9-bit mantissa
// RULE9 - True exponent is stored field minus bias
// RULE10 - Implied integer digit one when exponent nonzero
// RULE11 - Zero exponent means zero mantissa, no denormals
// RULE12 - Accumulator control: add, hold, load, clear
// RULE13 - Sample register loads sum when sample load set
// RULE14 - Host write takes effect two cycles later
// RULE15 - Interface mode pin feeds control from bus
// RULE16 - Direct controls registered with operand ports
package mac_control_pkg;

  // Control word value after reset.
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  // Clock cycles from the end of a host write to the new word taking effect.
  localparam int          WRITE_LATENCY = 2;
  // Accumulator and fixed output widths.
  localparam int          SUM_W         = 40;
  localparam int          FIXED_W       = 20;
  // Exponent bias used when encoding float results, and exponent ceiling.
  localparam int          FLOAT_BIAS    = 1;
  localparam int          FLOAT_EXP_MAX = 63;

  // Control word, most significant field first.
  typedef struct packed {  // RULE3
    logic [3:0] addSubSel;         // Real-time add/subtract selector.
    logic [1:0] internalDelaySel;  // Internal delay step count.
    logic       cascadeInDisable;  // Cascade input disable.
    logic [4:0] outBitSelect;      // Fixed output bit position.
    logic       roundTruncSel;     // Zero rounds, one truncates.
    logic       outFormatSel;      // Zero float output, one fixed.
    logic [1:0] multModeSel;       // Bit 1 wide mode, bit 0 unsigned.
  } ctrlWord_s;

  // Everything sampled from the pins in one bundle.
  typedef struct packed {
    logic [1:0]      accumCtl;     // Accumulator operation.
    logic            sampleLoad;   // Sample register load.
    logic [3:0]      multZeroCtl;  // Per-multiplier operand zeroing.
    logic [7:0][7:0] operands;     // Index zero is port A.
    logic [15:0]     hostDataBus;  // Host data bus input.
    logic            ifaceMode;    // One selects direct bus parameters.
    logic            csN;          // Chip select, active low.
    logic            wrN;          // Write strobe, active low.
    logic            rdN;          // Read strobe, active low.
  } pins_s;

  // Sixteen-bit float word.
  typedef struct packed {
    logic       sign;              // One means negative.
    logic [5:0] exponent;          // Biased exponent.
    logic [8:0] mantissa;          // Fraction below the binary point.
  } floatWord_s;

  // Accumulator operations.
  typedef enum logic [1:0] {
    ACC_ADD   = 2'b00,
    ACC_HOLD  = 2'b01,
    ACC_LOAD  = 2'b10,
    ACC_CLEAR = 2'b11
  } accumOp_e;

endpackage : mac_control_pkg

// >>> test/host_pipe_model.sv
// Host processor and upstream pipeline model that drives every block pin but clk_sys and sys_rst.
// Assumes the bench resolves the shared data bus from hostDataOeN.
`timescale 1ns/1ps
module host_pipe_model (
  input  wire logic              clk_sys,      // System clock.
  input  wire logic              hostDataOeN,  // Low while block drives.
  input  wire logic [15:0]       hostDataOut,  // Read data.
  output mac_control_pkg::pins_s pinsOut       // Every pin.
);
  logic [15:0] lastBus;  // Last level this side left on the bus.

  // Moves to just after the next rising edge.
  task automatic step();
    @(posedge clk_sys);
    #2;
  endtask : step

  // Idles: strobes high, datapath held and zeroed, released bus drifts.
  task automatic idle(input int n);
    repeat (n) begin
      step();
      pinsOut.csN = 1'b1;
      pinsOut.wrN = 1'b1;
      pinsOut.rdN = 1'b1;
      lastBus = ~lastBus;
      pinsOut.hostDataBus = lastBus;
      pinsOut.accumCtl = 2'b01;
      pinsOut.sampleLoad = 1'b0;
      pinsOut.multZeroCtl = 4'hf;
    end
  endtask : idle

  // Holds a write for four edges, then leaves the bus idle.
  task automatic write_word(input logic [15:0] w);
    step();
    pinsOut.csN = 1'b0;
    pinsOut.wrN = 1'b0;
    pinsOut.hostDataBus = w;
    lastBus = w;
    repeat (3) step();
    idle(4);
  endtask : write_word

  // Holds a read until the block drives the bus, at most eight edges.
  task automatic read_word(input logic sel, output logic [15:0] d,
                           output logic ok);
    step();
    pinsOut.csN = ~sel;
    pinsOut.rdN = 1'b0;
    ok = 1'b0;
    d = 16'h0000;
    for (int i = 0; i < 8 && !ok; i++) begin
      step();
      ok = (hostDataOeN === 1'b0);
      d = hostDataOut;
    end
    idle(4);
  endtask : read_word

  // Drives one direct-mode cycle of controls and operands together.
  task automatic cycle(input logic [15:0] w, input logic [1:0] acc,
                       input logic sample_load, input logic [3:0] mult_zero_ctl,
                       input logic [7:0][7:0] ops);
    step();
    pinsOut.ifaceMode = 1'b1;
    pinsOut.hostDataBus = w;
    pinsOut.accumCtl = acc;
    pinsOut.sampleLoad = sample_load;
    pinsOut.multZeroCtl = mult_zero_ctl;
    pinsOut.operands = ops;
  endtask : cycle

  // Every pin has a value from time zero.
  initial begin
    lastBus = 16'h0000;
    pinsOut = {2'b01, 1'b0, 4'hf, 64'h0, 16'h0, 1'b0, 3'b111};
  end
endmodule : host_pipe_model

// >>> test/tb.sv
// Self-checking bench for the multiply-accumulate control block.
// Assumes host_pipe_model drives all pins but clk_sys and sys_rst just after each rising edge.
`timescale 1ns/1ps
module tb;
  logic                   clk_sys;      // System clock.
  logic                   sys_rst;      // Synchronous reset.
  mac_control_pkg::pins_s pins;         // Pins from the model.
  logic [15:0]            busLevel;     // Resolved data bus.
  logic [15:0]            hostDataOut;  // Read data.
  logic                   hostDataOeN;  // Read drive enable.
  logic [19:0]            resultWord;   // Datapath result.
  logic [15:0]            activeCtrl;   // Host control register word.
  int                     failures;     // Mismatches seen.
  int                     num_checks;   // Comparisons made.
  logic [31:0]            lfsr;         // Random state.
  longint                 sumM;         // Model accumulator.
  longint                 smpM;         // Model sample register.
  logic [15:0]            rdData;       // Word returned by a read.
  logic                   rdOk;         // A read was answered.
  logic [31:0]            r;            // Scratch random word.
  logic [15:0]            w;            // Word under test.
  int                     n;            // Burst length.
  logic [15:0]            cf;           // Fixed fields of a burst.
  logic [15:0]            wOld;         // Word in force before a write.
  logic [19:0]            fx;           // Expected fixed result.
  logic [15:0] wpat [7] = '{16'h0003, 16'h0004, 16'h0008, 16'h01f0,
                            16'h0200, 16'h0c00, 16'hf000};
  logic [15:0] fpair [4] = '{16'h0101, 16'hfd01, 16'h0500, 16'h8080};

  // The block wins the bus only while it enables its drivers.
  assign busLevel = (hostDataOeN === 1'b0) ? hostDataOut : pins.hostDataBus;

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  mac_control u_mac_control (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .csN(pins.csN),
    .wrN(pins.wrN), .rdN(pins.rdN), .hostDataIn(busLevel),
    .ifaceModePin(pins.ifaceMode), .accumCtl(pins.accumCtl),
    .sampleLoad(pins.sampleLoad), .multZeroCtl(pins.multZeroCtl),
    .operandPortA(pins.operands[0]), .operandPortB(pins.operands[1]),
    .operandPortC(pins.operands[2]), .operandPortD(pins.operands[3]),
    .operandPortE(pins.operands[4]), .operandPortF(pins.operands[5]),
    .operandPortG(pins.operands[6]), .operandPortH(pins.operands[7]),
    .hostDataOut(hostDataOut), .hostDataOeN(hostDataOeN),
    .resultWord(resultWord), .activeCtrl(activeCtrl));

  host_pipe_model u_host_pipe_model (
    .clk_sys(clk_sys), .hostDataOeN(hostDataOeN),
    .hostDataOut(hostDataOut), .pinsOut(pins));

  // Steps the random source.
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
    return lfsr;
  endfunction : rnd

  // Encodes a sum as a float word with bias one and truncated fraction.
  function automatic logic [15:0] float_enc(longint v);
    longint m;
    int p;
    m = (v < 0) ? -v : v;
    p = 0;
    if (m == 0) return 16'h0000;
    while ((m >> (p + 1)) != 0) p++;
    return {v < 0, 6'(p + 1), (p >= 9) ? 9'(m >> (p - 9)) : 9'(m << (9 - p))};
  endfunction : float_enc

  // Reads an operand as unsigned, or signed at 8 or 16 bits.
  function automatic longint opv(input logic [15:0] v, input logic u,
                                 input logic wd);
    if (u) return longint'(v);
    return wd ? longint'($signed(v)) : longint'($signed(v[7:0]));
  endfunction : opv

  // Picks the fixed-point field of a sample, rounding unless truncating.
  function automatic logic [19:0] fixed_sel(input longint v, input int s,
                                            input logic tr);
    longint q;
    q = v >>> s;
    if (!tr && s > 0) q = q + ((v >>> (s - 1)) & 1);
    return q[19:0];
  endfunction : fixed_sel

  // Applies one datapath cycle to the reference model and the pins.
  task automatic drive(input logic [15:0] cw, input logic [1:0] a,
                       input logic s, input logic [3:0] z,
                       input logic [7:0][7:0] o);
    longint t;
    longint h;
    longint p [4];
    for (int i = 0; i < 4; i++) begin
      p[i] = z[i] ? 0 : opv({8'h00, o[2*i]}, cw[0], 1'b0) *
                        opv({8'h00, o[2*i+1]}, cw[0], 1'b0);
    end
    t = cw[12] ? p[0] - p[1] : p[0] + p[1];
    h = cw[13] ? p[2] - p[3] : p[2] + p[3];
    t = cw[14] ? t - h : t + h;
    if (cw[1]) begin
      // Wide mode pairs A:B with C:D; the zero bits still clear them.
      t = (z[0] ? 0 : opv({o[0], o[1]}, cw[0], 1'b1)) *
          (z[1] ? 0 : opv({o[2], o[3]}, cw[0], 1'b1));
    end
    t = cw[15] ? -t : t;
    case (a)
      2'b00: sumM = sumM + t;
      2'b10: sumM = t;
      2'b11: sumM = 0;
      default: sumM = sumM;
    endcase
    if (s) smpM = sumM;
    u_host_pipe_model.cycle(cw, a, s, z, o);
  endtask : drive

  // Holds accumulator and sample register while the pipeline drains.
  task automatic settle(input logic [15:0] cw);
    repeat (8) drive(cw, 2'b01, 1'b0, 4'hf, '0);
  endtask : settle

  // Compares a register-side word or flag.
  task automatic cmp_reg(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_reg

  // Compares a datapath result.
  task automatic cmp_res(input string nm, input logic [19:0] e,
                         input logic [19:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_res

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence: reset, register traffic, then direct-mode datapath.
  initial begin
    failures = 0;
    num_checks = 0;
    lfsr = 32'hf1a4c0a7;
    sumM = 0;
    smpM = 0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    #2;
    sys_rst = 1'b0;
    u_host_pipe_model.idle(2);
    cmp_reg("control after reset", 16'h0000, activeCtrl);
    cmp_reg("drive after reset", 16'h0001, {15'h0, hostDataOeN});
    cmp_res("result after reset", 20'h00000, resultWord);
    w = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      wOld = w;
      w = (i < 7) ? wpat[i] : r[15:0];
      u_host_pipe_model.write_word(w);
      cmp_reg("control before commit", wOld, activeCtrl);
      u_host_pipe_model.idle(1);
      cmp_reg("active control", w, activeCtrl);
      u_host_pipe_model.read_word(1'b1, rdData, rdOk);
      cmp_reg("read answered", 16'h0001, {15'h0, rdOk});
      cmp_reg("read data", w, rdData);
      cmp_reg("bus released", 16'h0001, {15'h0, hostDataOeN});
      if (failures != 0) report_and_stop();
    end
    u_host_pipe_model.read_word(1'b0, rdData, rdOk);
    cmp_reg("unselected read", 16'h0000, {15'h0, rdOk});
    for (int b = 0; b < 40; b++) begin
      r = rnd();
      n = 1 + int'(r[1:0]);
      // Fixed output, random bit position, rounding and multiply mode.
      cf = {4'h0, 3'b001, 1'b0, r[7:4], r[8], 1'b1, r[10:9]};
      for (int k = 0; k < n; k++) begin
        r = rnd();
        drive({r[3:0], cf[11:0]}, r[5:4], r[6], r[10:7], {rnd(), rnd()});
      end
      settle(cf);
      fx = fixed_sel(smpM, int'(cf[8:4]), cf[3]);
      cmp_res("fixed result", fx, resultWord);
      cmp_reg("host word kept", w, activeCtrl);
    end
    for (int i = 0; i < 4; i++) begin
      drive(16'h0208, 2'b10, 1'b1, 4'he, {48'h0, fpair[i]});
      settle(16'h0208);
      cmp_res("float result", {4'h0, float_enc(smpM)}, resultWord);
    end
    report_and_stop();
  end

  // Cuts a hang short.
  initial begin
    #1000000;
    failures++;
    report_and_stop();
  end
endmodule : tb
